// ===== core/arc_regs.sv
`timescale 1ns/10ps
`include "arc_cfg.svh"

module arc_regs (
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // core register port
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  output logic reg_rvalid,
  // converter status from the same clock
  input wire logic power_down,
  input wire logic conv_done,
  // rate controls
  output arc_pkg::arc_rate_t rate_q,
  output logic [`ARC_RATE_W-1:0] rate_x10_q,
  output logic rate_reserved_q,
  output logic chop_swap_q,
  output logic result_ready_q,
  // reference and excitation controls
  output arc_pkg::arc_vctl_t vctl_q,
  output arc_pkg::arc_ectl_t ectl_q,
  output logic exc_ref_missing_q
);

  // stored register images
  arc_pkg::arc_vref_t vref_q;
  arc_pkg::arc_exc_t exc_q;
  // decoder outputs, registered below
  logic [`ARC_RATE_W-1:0] rate_x10_d;
  logic rate_rsvd_d;
  // address hits
  logic hit_rate;
  logic hit_vref;
  logic hit_exc;

  assign hit_rate = reg_addr == `ARC_ADDR_RATE;
  assign hit_vref = reg_addr == `ARC_ADDR_VREF;
  assign hit_exc = reg_addr == `ARC_ADDR_EXC;

  // rate register; the output port is the register itself
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rate_q <= `ARC_RST_RATE;
    end else if (reg_wr && hit_rate) begin
      // chop, clock, mode, filter and rate all store as written
      rate_q <= reg_wdata;
    end
  end

  // reference register, reserved codes are kept as written
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      vref_q <= `ARC_RST_VREF;
    end else if (reg_wr && hit_vref) begin
      vref_q <= reg_wdata;
    end
  end

  // excitation register, read-only bits never store a one
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      exc_q <= `ARC_RST_EXC;
    end else if (reg_wr && hit_exc) begin
      exc_q <= reg_wdata & `ARC_EXC_WMASK;
    end
  end

  // registered read data; unmapped addresses read zero
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      reg_rdata <= 8'h00;
      reg_rvalid <= 1'b0;
    end else begin
      reg_rvalid <= reg_rd;
      if (!reg_rd) begin
        reg_rdata <= 8'h00;
      end else if (hit_rate) begin
        reg_rdata <= rate_q;
      end else if (hit_vref) begin
        reg_rdata <= vref_q;
      end else if (hit_exc) begin
        reg_rdata <= exc_q;
      end else begin
        reg_rdata <= 8'h00;
      end
    end
  end

  // rate code table
  arc_rate_lut u_lut (
    .code(rate_q.output_rate_code),
    .rate_x10(rate_x10_d),
    .reserved(rate_rsvd_d)
  );

  // decoded rate, one cycle behind the register
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      // matches the decode of the reset rate code, so no step at release
      rate_x10_q <= `ARC_RST_RATE_X10;
      rate_reserved_q <= 1'b0;
    end else begin
      rate_x10_q <= rate_x10_d;
      rate_reserved_q <= rate_rsvd_d;
    end
  end

  // chop phase: flips on each finished conversion while chop is on;
  // the averaged result is ready after the swapped half of each pair
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      chop_swap_q <= 1'b0;
      result_ready_q <= 1'b0;
    end else if (!rate_q.chop) begin
      // without chop every conversion is a result and no swap is held
      chop_swap_q <= 1'b0;
      result_ready_q <= conv_done;
    end else begin
      if (conv_done) begin
        chop_swap_q <= !chop_swap_q;
      end
      result_ready_q <= conv_done && chop_swap_q;
    end
  end

  // reference controls; power-down only silences the sleeping mode
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      vctl_q <= '0;
      vctl_q.neg_buffer_bypass <= 1'b1;
      vctl_q.use_first_pair <= 1'b1;
    end else begin
      vctl_q.vsource_low_monitor <= vref_q.vsource_monitor_cfg != `ARC_MON_OFF;
      vctl_q.vsource_third_monitor <=
        vref_q.vsource_monitor_cfg == `ARC_MON_THIRD;
      vctl_q.pull_together <= vref_q.vsource_monitor_cfg == `ARC_MON_PULL;
      vctl_q.pos_buffer_bypass <= vref_q.pos_buffer_bypass;
      vctl_q.neg_buffer_bypass <= vref_q.neg_buffer_bypass;
      vctl_q.use_first_pair <= vref_q.vsource_select == `ARC_SEL_FIRST;
      vctl_q.use_second_pair <= vref_q.vsource_select == `ARC_SEL_SECOND;
      vctl_q.use_internal <= vref_q.vsource_select == `ARC_SEL_INT;
      // reserved power code 11 leaves the reference off
      vctl_q.internal_on <= vref_q.internal_vsource_power == `ARC_PWR_ALWAYS ||
        (vref_q.internal_vsource_power == `ARC_PWR_SLEEP_OFF && !power_down);
    end
  end

  // excitation controls; the low-side switch opens in power-down
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      ectl_q <= '0;
    end else begin
      ectl_q.amp_rail_monitor_en <= exc_q.amp_rail_monitor_en;
      ectl_q.switch_closed <= exc_q.low_side_switch && !power_down;
      ectl_q.excitation_level <= exc_q.excitation_level;
    end
  end

  // status only: the host is expected to enable the reference first,
  // so hardware flags the slip instead of blocking the current
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      exc_ref_missing_q <= 1'b0;
    end else begin
      exc_ref_missing_q <= exc_q.excitation_level != 4'h0 &&
        vref_q.internal_vsource_power == `ARC_PWR_OFF;
    end
  end

  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  a_chop_swap_flip: assert property (
    rate_q.chop && conv_done |=> chop_swap_q != $past(chop_swap_q))
    else $error("chop phase did not flip");

  a_chop_pair_ready: assert property (
    rate_q.chop && conv_done && !chop_swap_q |=> !result_ready_q)
    else $error("result ready after unswapped half");

  a_clk_sel_store: assert property (
    reg_wr && hit_rate |=> rate_q.ext_clk == $past(reg_wdata[`ARC_RATE_CLK]))
    else $error("clock select not stored");

  a_mode_filt_store: assert property (
    reg_wr && hit_rate |=> rate_q.single_shot == $past(reg_wdata[`ARC_RATE_MODE])
      && rate_q.low_latency == $past(reg_wdata[`ARC_RATE_FILT]))
    else $error("mode or filter not stored");

  a_filter_store: assert property (
    reg_wr && hit_rate ##1 !(reg_wr && hit_rate) |=>
      rate_q.low_latency == $past(reg_wdata[`ARC_RATE_FILT], 2))
    else $error("filter bit lost");

  a_rate_table: assert property (
    reg_wr && hit_rate && reg_wdata[3:0] == 4'hb ##1 !(reg_wr && hit_rate) |=>
      rate_x10_q == 14'd10000 && !rate_reserved_q)
    else $error("rate code 1011 not 1000 per second");

  a_mon_third: assert property (
    vref_q.vsource_monitor_cfg == `ARC_MON_THIRD |=>
      vctl_q.vsource_third_monitor && vctl_q.vsource_low_monitor && !vctl_q.pull_together)
    else $error("third monitor decode wrong");

  a_buf_bypass: assert property (
    reg_wr && hit_vref ##1 !(reg_wr && hit_vref) |=>
      vctl_q.pos_buffer_bypass == $past(reg_wdata[5], 2) &&
      vctl_q.neg_buffer_bypass == $past(reg_wdata[4], 2))
    else $error("buffer bypass not applied");

  a_src_internal: assert property (
    vref_q.vsource_select == `ARC_SEL_INT |=> vctl_q.use_internal &&
      !vctl_q.use_first_pair && !vctl_q.use_second_pair)
    else $error("internal source not selected");

  a_pwr_sleep: assert property (
    vref_q.internal_vsource_power == `ARC_PWR_SLEEP_OFF && power_down |=>
      !vctl_q.internal_on)
    else $error("reference stayed on in power-down");

  a_exc_zero_bits: assert property (
    reg_rd && hit_exc |=> reg_rvalid && reg_rdata[5:4] == 2'b00)
    else $error("excitation bits 5:4 not zero");

  a_vref_readback: assert property (
    reg_wr && hit_vref ##1 reg_rd && hit_vref && !reg_wr |=>
      reg_rdata == $past(reg_wdata, 2))
    else $error("reference register read-back differs");

  // idle cycles leave the read bus quiet, so a stray strobe is visible
  a_rdata_idle: assert property (
    !reg_rd |=> !reg_rvalid && reg_rdata == 8'h00)
    else $error("read bus not idle after no read");

  // a read returns the image as it stood at the read edge
  a_rate_readback: assert property (
    reg_rd && hit_rate |=> reg_rvalid && reg_rdata == $past(rate_q))
    else $error("rate register read-back differs");

  // excitation writes keep the read-only pair at zero
  a_exc_store: assert property (
    reg_wr && hit_exc |=> exc_q.zero == 2'h0 &&
      exc_q.excitation_level == $past(reg_wdata[3:0]) &&
      exc_q.low_side_switch == $past(reg_wdata[6]))
    else $error("excitation write not stored as masked");

  // without chop each conversion is a result and no swap is held
  a_chop_off_ready: assert property (
    !rate_q.chop |=> result_ready_q == $past(conv_done) && !chop_swap_q)
    else $error("result pulse wrong with chop off");

  // reserved rate codes flag and fall back to the slowest rate
  a_rate_reserved: assert property (
    rate_q.output_rate_code > 4'hb |=> rate_reserved_q && rate_x10_q == 14'h0019)
    else $error("reserved rate code not flagged");

  // code 01 keeps only the low monitor
  a_mon_low: assert property (
    vref_q.vsource_monitor_cfg == `ARC_MON_LOW |=>
      vctl_q.vsource_low_monitor && !vctl_q.vsource_third_monitor && !vctl_q.pull_together)
    else $error("low monitor decode wrong");

  // code 11 adds the pull-together to the low monitor
  a_mon_pull: assert property (
    vref_q.vsource_monitor_cfg == `ARC_MON_PULL |=>
      vctl_q.vsource_low_monitor && vctl_q.pull_together && !vctl_q.vsource_third_monitor)
    else $error("pull-together decode wrong");

  // code 10 holds the reference up whatever power-down says
  a_pwr_always: assert property (
    vref_q.internal_vsource_power == `ARC_PWR_ALWAYS |=> vctl_q.internal_on)
    else $error("always-on reference dropped");

  // off and the reserved code both leave the reference down
  a_pwr_off: assert property (
    vref_q.internal_vsource_power != `ARC_PWR_ALWAYS &&
      vref_q.internal_vsource_power != `ARC_PWR_SLEEP_OFF |=> !vctl_q.internal_on)
    else $error("reference on with off or reserved code");

  // the low-side switch opens in power-down whatever the register holds
  a_switch_pd: assert property (
    power_down |=> !ectl_q.switch_closed)
    else $error("low-side switch closed in power-down");

  // scenarios the bench is expected to reach
  c_chop_pair: cover property (rate_q.chop && conv_done ##[1:20] result_ready_q);
  c_single_shot: cover property (reg_wr && hit_rate && reg_wdata[`ARC_RATE_MODE]);
  c_ref_always: cover property (vctl_q.internal_on && power_down);
  c_rate_reserved: cover property (rate_reserved_q);
  c_ref_missing: cover property (exc_ref_missing_q);

endmodule

// ===== core/arc_cfg.svh
`ifndef ARC_CFG_SVH
`define ARC_CFG_SVH

// register addresses on the core register port
`define ARC_ADDR_RATE 8'h04
`define ARC_ADDR_VREF 8'h05
`define ARC_ADDR_EXC 8'h06

// reset values
`define ARC_RST_RATE 8'h14
`define ARC_RST_VREF 8'h10
`define ARC_RST_EXC 8'h00
// decoded reset rate, 20 per second in tenths
`define ARC_RST_RATE_X10 14'h00c8

// writable bits of the excitation register, bits 5:4 read as zero
`define ARC_EXC_WMASK 8'hcf

// rate register field positions
`define ARC_RATE_CHOP 7
`define ARC_RATE_CLK 6
`define ARC_RATE_MODE 5
`define ARC_RATE_FILT 4

// reference monitor encodings
`define ARC_MON_OFF 2'b00
`define ARC_MON_LOW 2'b01
`define ARC_MON_THIRD 2'b10
`define ARC_MON_PULL 2'b11

// reference source encodings
`define ARC_SEL_FIRST 2'b00
`define ARC_SEL_SECOND 2'b01
`define ARC_SEL_INT 2'b10

// internal reference power encodings
`define ARC_PWR_OFF 2'b00
`define ARC_PWR_SLEEP_OFF 2'b01
`define ARC_PWR_ALWAYS 2'b10

// width of the decoded rate, tenths of a sample per second
`define ARC_RATE_W 14

`endif

// ===== core/arc_pkg.sv
package arc_pkg;

  // conversion-rate register image, msb first
  typedef struct packed {
    logic chop;
    logic ext_clk;
    logic single_shot;
    logic low_latency;
    logic [3:0] output_rate_code;
  } arc_rate_t;

  // voltage-standard control register image
  typedef struct packed {
    logic [1:0] vsource_monitor_cfg;
    logic pos_buffer_bypass;
    logic neg_buffer_bypass;
    logic [1:0] vsource_select;
    logic [1:0] internal_vsource_power;
  } arc_vref_t;

  // excitation magnitude register image
  typedef struct packed {
    logic amp_rail_monitor_en;
    logic low_side_switch;
    logic [1:0] zero;
    logic [3:0] excitation_level;
  } arc_exc_t;

  // decoded reference controls toward the analog side
  typedef struct packed {
    logic vsource_low_monitor;
    logic vsource_third_monitor;
    logic pull_together;
    logic pos_buffer_bypass;
    logic neg_buffer_bypass;
    logic use_first_pair;
    logic use_second_pair;
    logic use_internal;
    logic internal_on;
  } arc_vctl_t;

  // decoded excitation controls
  typedef struct packed {
    logic amp_rail_monitor_en;
    logic switch_closed;
    logic [3:0] excitation_level;
  } arc_ectl_t;

endpackage

// ===== core/arc_rate_lut.sv
`timescale 1ns/10ps
`include "arc_cfg.svh"

// maps the output rate code to tenths of samples per second
module arc_rate_lut (
  // code in
  input wire logic [3:0] code,
  // decoded rate out
  output logic [`ARC_RATE_W-1:0] rate_x10,
  output logic reserved
);

  // pure table, the caller registers the result
  always_comb begin
    reserved = 1'b0;
    unique case (code)
      4'h0: rate_x10 = 14'h0019; // 2.5 per second
      4'h1: rate_x10 = 14'h0032; // 5 per second
      4'h2: rate_x10 = 14'h0064; // 10 per second
      4'h3: rate_x10 = 14'h00a6; // 16.6 per second
      4'h4: rate_x10 = 14'h00c8; // 20 per second
      4'h5: rate_x10 = 14'h01f4; // 50 per second
      4'h6: rate_x10 = 14'h0258; // 60 per second
      4'h7: rate_x10 = 14'h03e8; // 100 per second
      4'h8: rate_x10 = 14'h07d0; // 200 per second
      4'h9: rate_x10 = 14'h0fa0; // 400 per second
      4'ha: rate_x10 = 14'h1f40; // 800 per second
      4'hb: rate_x10 = 14'h2710; // 1000 per second
      default: begin
        // codes above 1011 are reserved, fall back to the slowest rate
        rate_x10 = 14'h0019;
        reserved = 1'b1;
      end
    endcase
  end

endmodule

// ===== tb/tb.sv
`timescale 1ns/10ps
module tb;
  // clock, reset and register port
  logic clk;
  logic rstn;
  logic reg_wr;
  logic reg_rd;
  logic [7:0] reg_addr;
  logic [7:0] reg_wdata;
  logic [7:0] reg_rdata;
  logic reg_rvalid;
  // converter status inputs
  logic power_down;
  logic conv_done;
  // decoded outputs
  arc_pkg::arc_rate_t rate_q;
  logic [13:0] rate_x10_q;
  logic rate_reserved_q;
  logic chop_swap_q;
  logic result_ready_q;
  arc_pkg::arc_vctl_t vctl_q;
  arc_pkg::arc_ectl_t ectl_q;
  logic exc_ref_missing_q;
  // expected read data, oldest first
  logic [7:0] exp_q[$];
  int n_mismatch = 0;
  int num_checks = 0;
  logic [31:0] seed = 32'h15; // starts at 21
  logic [7:0] sh_vref;
  logic [7:0] v;

  arc_regs u_arc_regs (.clk(clk), .rstn(rstn), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .reg_rvalid(reg_rvalid), .power_down(power_down), .conv_done(conv_done),
    .rate_q(rate_q), .rate_x10_q(rate_x10_q), .rate_reserved_q(rate_reserved_q),
    .chop_swap_q(chop_swap_q), .result_ready_q(result_ready_q), .vctl_q(vctl_q),
    .ectl_q(ectl_q), .exc_ref_missing_q(exc_ref_missing_q));

  // 100 MHz clock
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // xorshift source, fixed start so runs repeat
  function logic [7:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed[7:0];
  endfunction

  // tenths of samples per second; reserved codes decode to the slowest rate
  function automatic logic [15:0] rate10(input logic [3:0] c);
    logic [15:0] t[12] = '{16'h0019, 16'h0032, 16'h0064, 16'h00a6, 16'h00c8, 16'h01f4,
      16'h0258, 16'h03e8, 16'h07d0, 16'h0fa0, 16'h1f40, 16'h2710};
    return (c > 4'hb) ? 16'h0019 : t[c];
  endfunction

  // reference decode: low monitor on for any nonzero monitor code
  function automatic logic [15:0] vexp(input logic [7:0] r, input logic pd);
    return {7'h0, r[7:6] != 2'b00, r[7:6] == 2'b10, r[7:6] == 2'b11, r[5], r[4],
      r[3:2] == 2'b00, r[3:2] == 2'b01, r[3:2] == 2'b10,
      (r[1:0] == 2'b10) | ((r[1:0] == 2'b01) & ~pd)};
  endfunction

  task automatic chk(input string name, input logic [15:0] e, input logic [15:0] g);
    num_checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", name, e, g);
    end
  endtask

  // one-cycle strobes, inputs move 1 ns after the edge
  task wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    #1 reg_wr = 1'b1;
    reg_addr = a;
    reg_wdata = d;
    @(posedge clk);
    #1 reg_wr = 1'b0;
  endtask

  task rd(input logic [7:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    @(posedge clk);
    #1 reg_rd = 1'b1;
    reg_addr = a;
    @(posedge clk);
    #1 reg_rd = 1'b0;
  endtask

  // write then read the same place back to back, expecting the written value
  task wrrd(input logic [7:0] a, input logic [7:0] d);
    exp_q.push_back(d);
    @(posedge clk);
    #1 reg_wr = 1'b1;
    reg_addr = a;
    reg_wdata = d;
    @(posedge clk);
    #1 reg_wr = 1'b0;
    reg_rd = 1'b1;
    @(posedge clk);
    #1 reg_rd = 1'b0;
  endtask

  task pulse();
    @(posedge clk);
    #1 conv_done = 1'b1;
    @(posedge clk);
    #1 conv_done = 1'b0;
  endtask

  task print_verdict();
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  // read watcher, samples mid-cycle where registered outputs are settled
  always @(negedge clk) begin
    if (reg_rvalid === 1'b1) begin
      if (exp_q.size() == 0) begin
        n_mismatch++;
        $display("Error reg_rvalid expected 0 seen 1");
      end else begin
        chk("reg_rdata", 16'(exp_q.pop_front()), 16'(reg_rdata));
      end
    end
  end

  // hang guard
  initial begin
    for (int k = 0; k < 20000; k++) @(posedge clk);
    n_mismatch++;
    $display("Error timeout expected done seen running");
    print_verdict();
  end

  initial begin
    rstn = 1'b0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    power_down = 1'b0;
    conv_done = 1'b0;
    repeat (16) @(posedge clk);
    #1 rstn = 1'b1;
    // reset images and an unmapped read
    chk("rate_x10", 16'h00c8, 16'(rate_x10_q));
    chk("vctl", 16'h0018, 16'(vctl_q));
    rd(8'h04, 8'h14);
    rd(8'h05, 8'h10);
    rd(8'h06, 8'h00);
    rd(8'h07, 8'h00);
    // every rate code, random mode bits above it
    for (int i = 0; i < 16; i++) begin
      v = xs();
      v[3:0] = i[3:0];
      wr(8'h04, v);
      rd(8'h04, v);
      chk("rate_q", 16'(v), 16'(rate_q));
      chk("rate_x10", rate10(i[3:0]), 16'(rate_x10_q));
      chk("reserved", 16'(i > 11), 16'(rate_reserved_q));
    end
    // every monitor, source and power code, random buffers and power-down
    for (int i = 0; i < 16; i++) begin
      v = xs();
      v[7:6] = i[1:0];
      v[3:2] = i[3:2];
      v[1:0] = i[1:0] ^ i[3:2];
      sh_vref = v;
      power_down = seed[9];
      wrrd(8'h05, v);
      chk("vctl", vexp(v, power_down), 16'(vctl_q));
    end
    // excitation register, bits 5:4 never stick; power-down follows a random bit
    for (int i = 0; i < 16; i++) begin
      v = xs();
      v[3:0] = i[3:0];
      power_down = v[5];
      // first half leaves the reference off on purpose to raise the flag;
      // from here on the host sets it up in the recommended order
      if (i == 8) begin
        sh_vref = 8'h3a;
        wrrd(8'h05, sh_vref);
        chk("vctl", vexp(sh_vref, power_down), 16'(vctl_q));
      end
      wr(8'h06, v);
      rd(8'h06, v & 8'hcf);
      chk("ectl", {10'h0, v[7], v[6] & ~power_down, v[3:0]}, 16'(ectl_q));
      chk("ref_missing", 16'(v[3:0] != 0 && sh_vref[1:0] == 2'b00),
        16'(exc_ref_missing_q));
    end
    // a write to an unmapped place changes nothing
    wr(8'h07, 8'hff);
    rd(8'h05, sh_vref);
    rd(8'h06, v & 8'hcf);
    // chop: swap on the first of a pair, result on the second
    power_down = 1'b0;
    wr(8'h04, 8'h94);
    pulse();
    chk("chop_swap", 16'h1, 16'(chop_swap_q));
    chk("result_ready", 16'h0, 16'(result_ready_q));
    pulse();
    chk("chop_swap", 16'h0, 16'(chop_swap_q));
    chk("result_ready", 16'h1, 16'(result_ready_q));
    wr(8'h04, 8'h14);
    pulse();
    chk("result_ready", 16'h1, 16'(result_ready_q));
    // reset in mid-run restores the images
    wr(8'h05, 8'h2e);
    @(posedge clk);
    #1 rstn = 1'b0;
    repeat (2) @(posedge clk);
    #1 rstn = 1'b1;
    rd(8'h05, 8'h10);
    rd(8'h04, 8'h14);
    repeat (4) @(posedge clk);
    #1;
    chk("pending_reads", 16'h0, 16'(exp_q.size()));
    print_verdict();
  end
endmodule
